// File: core/cmcsb_map.svh
`ifndef CMCSB_MAP_SVH
`define CMCSB_MAP_SVH
// register addresses on the control port
`define CMCSB_ADDR_MISC 7'h49
`define CMCSB_ADDR_TIE_CTRL 7'h4b
`define CMCSB_ADDR_P2P 7'h4c
`define CMCSB_ADDR_PEAK 7'h4d
`define CMCSB_ADDR_ANALOG_MUTE_FLAG 7'h4e
`define CMCSB_ADDR_TIE_MAN 7'h4f
// reset values
`define CMCSB_MISC_RST 9'h000
`define CMCSB_TIE_CTRL_RST 9'h000
`define CMCSB_ANALOG_MUTE_FLAG_RST 9'h000
`define CMCSB_TIE_MAN_RST 9'h000
// writable masks
`define CMCSB_MISC_MASK 9'h1ff
`define CMCSB_TIE_CTRL_MASK 9'h087
`define CMCSB_ANALOG_MUTE_FLAG_MASK 9'h040
`define CMCSB_TIE_MAN_MASK 9'h1f8
// misc_control fields
`define CMCSB_MISC_OS256 0
`define CMCSB_MISC_PLLPASS 1
`define CMCSB_MISC_SMZERO 2
`define CMCSB_MISC_NFNODLY 3
`define CMCSB_MISC_SFDIS 4
`define CMCSB_MISC_SFFLUSH 5
`define CMCSB_MISC_SFTHR_LO 6
`define CMCSB_MISC_SFTHR_HI 7
`define CMCSB_MISC_FORCE4W 8
// output_tie_off_control fields
`define CMCSB_TIE_REF6K 0
`define CMCSB_TIE_REF160K 1
`define CMCSB_TIE_REF600K 2
`define CMCSB_TIE_SPKSTAGE 7
// automute_control_status fields
`define CMCSB_AM_LIMIT 0
`define CMCSB_AM_DIGITAL_MUTE_FLAG 2
`define CMCSB_AM_ANALOG_MUTE_FLAG 3
`define CMCSB_AM_NGATE 4
`define CMCSB_AM_SPEAKER_SUPPLY_HIGH_FLAG 5
`define CMCSB_AM_SRC 6
// output_tie_off_manual fields
`define CMCSB_MAN_MONO 3
`define CMCSB_MAN_POS 4
`define CMCSB_MAN_NEG 5
`define CMCSB_MAN_BUFLO 6
`define CMCSB_MAN_BUFHI 7
`define CMCSB_MAN_EN 8
// timing and level counts
`define CMCSB_SF_EDGES_253 9'h0fd
`define CMCSB_SF_EDGES_254 9'h0fe
`define CMCSB_SF_EDGES_255 9'h0ff
`define CMCSB_NOTCH_DELAY 10'h200
`define CMCSB_LIMIT_LEVEL 24'he0_0000
`endif

// File: core/cmcsb_pkg.sv
package cmcsb_pkg;
  typedef struct packed {
    logic two_wire;
    logic spi_16;
    logic spi_24;
  } cmcsb_if_mode_t;
  typedef struct packed {
    logic buf_hi;
    logic buf_lo;
    logic neg_spk;
    logic pos_spk;
    logic mono;
  } cmcsb_tie_sw_t;
  typedef struct packed {
    logic ref_600k;
    logic ref_160k;
    logic ref_6k;
  } cmcsb_ref_sw_t;
  typedef enum logic [1:0] {
    CMCSB_NF_OFF,
    CMCSB_NF_WAIT,
    CMCSB_NF_USE
  } cmcsb_nf_state_t;
endpackage

// File: core/cmcsb_bank.sv
`timescale 1ns/100ps
`include "cmcsb_map.svh"
// Overview of operation
// - override bit forces DAC 256x oversampling
// - unlocked PLL output blocked unless pass set
// - softmute-zero bit forces limiter output zero while softmute is active
// - notch output waits 512 samples unless bypassed
// - short-frame detection active while disable bit zero
// - flush bit resets DSP on short frame
// - threshold codes select 255, 253, 254 edges
// - mode pin picks 2-wire or 16-bit SPI
// - force bit selects 24-bit 4-wire SPI
// - manual ref tie bits close ground switches
// - stage bit picks two or three stages
// - read-only peak-to-peak level readout
// - read-only rectified peak level readout
// - limiter flag set above 87.5% full scale
// - digital mute flag when DAC gain zero
// - analog mute flag while automute applied
// - noise gate flag while below threshold
// - supply high flag from 4.0V comparator
// - automute source attenuator input or serial data
// - manual override enable gates tie-off bits
// - manual mono and speaker tie switches forced closed or open
// - buffer bypass closes while buffer disabled
module cmcsb_bank (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic [6:0] wr_addr_in,
  input wire logic [8:0] wr_data_in,
  input wire logic [6:0] rd_addr_in,
  output logic [8:0] rd_data_out,
  input wire logic mclk_in,
  input wire logic frame_sync_in,
  input wire logic if_mode_pin_in,
  input wire logic speaker_supply_high_in,
  input wire logic gen_os_256_in,
  input wire logic pll_locked_in,
  input wire logic pll_osc_in,
  input wire logic softmute_in,
  input wire logic notch_en_in,
  input wire logic sample_tick_in,
  input wire logic [8:0] peak_to_peak_value_in,
  input wire logic [8:0] peak_value_in,
  input wire logic [23:0] signal_mag_in,
  input wire logic [7:0] dac_gain_in,
  input wire logic automute_applied_in,
  input wire logic noise_gate_active_in,
  input wire logic [23:0] atten_in_data_in,
  input wire logic [23:0] serial_playback_input_in,
  input wire cmcsb_pkg::cmcsb_ref_sw_t pm_ref_sw_in,
  input wire cmcsb_pkg::cmcsb_tie_sw_t auto_tie_sw_in,
  input wire logic [1:0] buf_disabled_in,
  output logic dac_os_256_out,
  output logic pll_clk_out,
  output logic limiter_force_zero_out,
  output logic notch_use_out,
  output logic short_frame_out,
  output logic dsp_flush_out,
  output cmcsb_pkg::cmcsb_if_mode_t if_mode_out,
  output cmcsb_pkg::cmcsb_ref_sw_t ref_sw_out,
  output logic speaker_amp_stage_select_out,
  output logic [23:0] automute_data_out,
  output cmcsb_pkg::cmcsb_tie_sw_t tie_sw_out
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: mclk, fs, mode pin, supply comparator
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic mclk_prev_q;
  logic fs_prev_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {speaker_supply_high_in, if_mode_pin_in,
                     frame_sync_in, mclk_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= pin_sync_q[0];
      fs_prev_q <= pin_sync_q[1];
    end
  end

  logic mclk_rise;
  logic fs_rise;
  assign mclk_rise = pin_sync_q[0] & ~mclk_prev_q;
  assign fs_rise = pin_sync_q[1] & ~fs_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // writable registers
  logic [8:0] misc_q;
  logic [8:0] tie_ctrl_q;
  logic [8:0] analog_mute_flag_q;
  logic [8:0] tie_man_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      misc_q <= `CMCSB_MISC_RST;
      tie_ctrl_q <= `CMCSB_TIE_CTRL_RST;
      analog_mute_flag_q <= `CMCSB_ANALOG_MUTE_FLAG_RST;
      tie_man_q <= `CMCSB_TIE_MAN_RST;
    end else if (wr_en_in) begin
      // fixed-zero positions never store, so they read back zero
      case (wr_addr_in)
        `CMCSB_ADDR_MISC: misc_q <= wr_data_in & `CMCSB_MISC_MASK;
        `CMCSB_ADDR_TIE_CTRL: begin
          tie_ctrl_q <= wr_data_in & `CMCSB_TIE_CTRL_MASK;
        end
        `CMCSB_ADDR_ANALOG_MUTE_FLAG: analog_mute_flag_q <= wr_data_in & `CMCSB_ANALOG_MUTE_FLAG_MASK;
        `CMCSB_ADDR_TIE_MAN: begin
          tie_man_q <= wr_data_in & `CMCSB_TIE_MAN_MASK;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status bits and readback
  logic limit_flag;
  logic digital_mute_flag_flag;
  logic [8:0] status_word;
  assign limit_flag = signal_mag_in > `CMCSB_LIMIT_LEVEL;
  assign digital_mute_flag_flag = dac_gain_in == 8'h00;

  always_comb begin
    status_word = analog_mute_flag_q;
    status_word[`CMCSB_AM_LIMIT] = limit_flag;
    status_word[`CMCSB_AM_DIGITAL_MUTE_FLAG] = digital_mute_flag_flag;
    status_word[`CMCSB_AM_ANALOG_MUTE_FLAG] = automute_applied_in;
    status_word[`CMCSB_AM_NGATE] = noise_gate_active_in;
    status_word[`CMCSB_AM_SPEAKER_SUPPLY_HIGH_FLAG] = pin_sync_q[3];
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_data_out <= 9'h000;
    end else begin
      case (rd_addr_in)
        `CMCSB_ADDR_MISC: rd_data_out <= misc_q;
        `CMCSB_ADDR_TIE_CTRL: rd_data_out <= tie_ctrl_q;
        `CMCSB_ADDR_P2P: rd_data_out <= peak_to_peak_value_in;
        `CMCSB_ADDR_PEAK: rd_data_out <= peak_value_in;
        `CMCSB_ADDR_ANALOG_MUTE_FLAG: rd_data_out <= status_word;
        `CMCSB_ADDR_TIE_MAN: rd_data_out <= tie_man_q;
        default: rd_data_out <= 9'h000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock and DAC controls
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dac_os_256_out <= 1'b0;
      limiter_force_zero_out <= 1'b0;
      speaker_amp_stage_select_out <= 1'b0;
      automute_data_out <= 24'h00_0000;
    end else begin
      dac_os_256_out <= misc_q[`CMCSB_MISC_OS256] | gen_os_256_in;
      limiter_force_zero_out <= softmute_in &
                                misc_q[`CMCSB_MISC_SMZERO];
      speaker_amp_stage_select_out <= tie_ctrl_q[`CMCSB_TIE_SPKSTAGE];
      automute_data_out <= analog_mute_flag_q[`CMCSB_AM_SRC] ?
                           serial_playback_input_in :
                           atten_in_data_in;
    end
  end

  // gating is combinational so the oscillator passes undelayed
  assign pll_clk_out = pll_osc_in &
                       (pll_locked_in | misc_q[`CMCSB_MISC_PLLPASS]);

  ////////////////////////////////////////////////////////////////////////
  // notch filter output delay
  cmcsb_pkg::cmcsb_nf_state_t nf_state_q;
  logic [9:0] nf_cnt_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      nf_state_q <= cmcsb_pkg::CMCSB_NF_OFF;
      nf_cnt_q <= 10'h000;
    end else if (!notch_en_in) begin
      nf_state_q <= cmcsb_pkg::CMCSB_NF_OFF;
      nf_cnt_q <= 10'h000;
    end else begin
      case (nf_state_q)
        cmcsb_pkg::CMCSB_NF_OFF: begin
          nf_cnt_q <= 10'h000;
          nf_state_q <= misc_q[`CMCSB_MISC_NFNODLY] ?
                        cmcsb_pkg::CMCSB_NF_USE :
                        cmcsb_pkg::CMCSB_NF_WAIT;
        end
        cmcsb_pkg::CMCSB_NF_WAIT: begin
          if (misc_q[`CMCSB_MISC_NFNODLY]) begin
            nf_state_q <= cmcsb_pkg::CMCSB_NF_USE;
          end else if (sample_tick_in) begin
            nf_cnt_q <= nf_cnt_q + 10'h001;
            if (nf_cnt_q == `CMCSB_NOTCH_DELAY - 10'h001) begin
              nf_state_q <= cmcsb_pkg::CMCSB_NF_USE;
            end
          end
        end
        cmcsb_pkg::CMCSB_NF_USE: nf_state_q <= cmcsb_pkg::CMCSB_NF_USE;
        default: nf_state_q <= cmcsb_pkg::CMCSB_NF_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      notch_use_out <= 1'b0;
    end else begin
      notch_use_out <= notch_en_in &
                       (nf_state_q == cmcsb_pkg::CMCSB_NF_USE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // short frame detection on master clock edges
  function automatic logic [8:0] sf_limit(input logic [1:0] code);
    case (code)
      2'b01: sf_limit = `CMCSB_SF_EDGES_253;
      2'b10: sf_limit = `CMCSB_SF_EDGES_254;
      default: sf_limit = `CMCSB_SF_EDGES_255;
    endcase
  endfunction

  logic [8:0] edge_cnt_q;
  logic frame_seen_q;
  logic sf_event;
  logic [8:0] edges_so_far;

  // an mclk edge in the same cycle as fs rise still belongs to this frame;
  // held at full count so a saturated counter cannot wrap back to zero
  assign edges_so_far = (edge_cnt_q == 9'h1ff) ? 9'h1ff :
                        edge_cnt_q + {8'h00, mclk_rise};
  assign sf_event = fs_rise & frame_seen_q &
                    ~misc_q[`CMCSB_MISC_SFDIS] &
                    (edges_so_far < sf_limit(
                       misc_q[`CMCSB_MISC_SFTHR_HI:`CMCSB_MISC_SFTHR_LO]));

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      edge_cnt_q <= 9'h000;
      frame_seen_q <= 1'b0;
    end else if (fs_rise) begin
      edge_cnt_q <= 9'h000;
      frame_seen_q <= 1'b1;
    end else if (mclk_rise && edge_cnt_q != 9'h1ff) begin
      // saturates so long frames never wrap into short ones
      edge_cnt_q <= edge_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      short_frame_out <= 1'b0;
      dsp_flush_out <= 1'b0;
    end else begin
      short_frame_out <= sf_event;
      dsp_flush_out <= sf_event & misc_q[`CMCSB_MISC_SFFLUSH];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control interface selection and analog switches
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      if_mode_out <= 3'b100;
      ref_sw_out <= 3'b000;
      tie_sw_out <= 5'h00;
    end else begin
      if (misc_q[`CMCSB_MISC_FORCE4W]) begin
        if_mode_out <= 3'b001;
      end else begin
        if_mode_out <= pin_sync_q[2] ? 3'b010 : 3'b100;
      end
      ref_sw_out.ref_6k <= tie_ctrl_q[`CMCSB_TIE_REF6K] |
                           pm_ref_sw_in.ref_6k;
      ref_sw_out.ref_160k <= tie_ctrl_q[`CMCSB_TIE_REF160K] |
                             pm_ref_sw_in.ref_160k;
      ref_sw_out.ref_600k <= tie_ctrl_q[`CMCSB_TIE_REF600K] |
                             pm_ref_sw_in.ref_600k;
      if (tie_man_q[`CMCSB_MAN_EN]) begin
        tie_sw_out.mono <= tie_man_q[`CMCSB_MAN_MONO];
        tie_sw_out.pos_spk <= tie_man_q[`CMCSB_MAN_POS];
        tie_sw_out.neg_spk <= tie_man_q[`CMCSB_MAN_NEG];
        tie_sw_out.buf_lo <= (tie_man_q[`CMCSB_MAN_BUFLO] &
                              buf_disabled_in[0]) |
                             auto_tie_sw_in.buf_lo;
        tie_sw_out.buf_hi <= (tie_man_q[`CMCSB_MAN_BUFHI] &
                              buf_disabled_in[1]) |
                             auto_tie_sw_in.buf_hi;
      end else begin
        tie_sw_out <= auto_tie_sw_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  chk_os_override: assert property (
    misc_q[`CMCSB_MISC_OS256] |=> dac_os_256_out)
    else $error("oversampling override not applied");
  chk_pll_gate: assert property (
    (!pll_locked_in && !misc_q[`CMCSB_MISC_PLLPASS]) |-> !pll_clk_out)
    else $error("pll output not gated while unlocked");
  chk_softmute_zero: assert property (
    (softmute_in && misc_q[`CMCSB_MISC_SMZERO]) |=> limiter_force_zero_out)
    else $error("softmute zero not forced");
  chk_notch_wait: assert property (
    ($rose(notch_en_in) && !misc_q[`CMCSB_MISC_NFNODLY]) |=>
    !notch_use_out [*8])
    else $error("notch output used before delay");
  chk_sf_disable: assert property (
    $past(misc_q[`CMCSB_MISC_SFDIS]) |-> !short_frame_out)
    else $error("short frame seen while disabled");
  chk_flush_gate: assert property (
    dsp_flush_out |-> short_frame_out && $past(misc_q[`CMCSB_MISC_SFFLUSH]))
    else $error("flush without enabled short frame");
  chk_sf_limit: assert property (
    sf_event |-> (edges_so_far < `CMCSB_SF_EDGES_255) &&
    (misc_q[`CMCSB_MISC_SFTHR_HI:`CMCSB_MISC_SFTHR_LO] != 2'b01 ||
     edges_so_far < `CMCSB_SF_EDGES_253) &&
    (misc_q[`CMCSB_MISC_SFTHR_HI:`CMCSB_MISC_SFTHR_LO] != 2'b10 ||
     edges_so_far < `CMCSB_SF_EDGES_254))
    else $error("short frame above edge limit");
  chk_spi_force: assert property (
    misc_q[`CMCSB_MISC_FORCE4W] |=> if_mode_out == 3'b001)
    else $error("four-wire mode not forced");
  chk_tie_auto: assert property (
    !tie_man_q[`CMCSB_MAN_EN] |=> tie_sw_out == $past(auto_tie_sw_in))
    else $error("tie switches not automatic");
  chk_digital_mute_flag_read: assert property (
    (rd_addr_in == `CMCSB_ADDR_ANALOG_MUTE_FLAG && dac_gain_in == 8'h00) |=>
    rd_data_out[`CMCSB_AM_DIGITAL_MUTE_FLAG])
    else $error("digital mute flag not reported");
  chk_two_wire_pin: assert property (
    (!misc_q[`CMCSB_MISC_FORCE4W] && !pin_sync_q[2]) |=>
    if_mode_out == 3'b100)
    else $error("two-wire mode not selected by pin");
  chk_spi16_pin: assert property (
    (!misc_q[`CMCSB_MISC_FORCE4W] && pin_sync_q[2]) |=>
    if_mode_out == 3'b010)
    else $error("16-bit serial mode not selected by pin");
  chk_ref_manual: assert property (
    tie_ctrl_q[`CMCSB_TIE_REF6K] |=> ref_sw_out.ref_6k)
    else $error("manual reference tie not closed");
  chk_amp_stage: assert property (
    speaker_amp_stage_select_out == $past(tie_ctrl_q[`CMCSB_TIE_SPKSTAGE]))
    else $error("speaker stage select not following register");
  chk_limit_read: assert property (
    (rd_addr_in == `CMCSB_ADDR_ANALOG_MUTE_FLAG && signal_mag_in > `CMCSB_LIMIT_LEVEL)
    |=> rd_data_out[`CMCSB_AM_LIMIT])
    else $error("limiter flag not reported");
  chk_am_source: assert property (
    analog_mute_flag_q[`CMCSB_AM_SRC] |=>
    automute_data_out == $past(serial_playback_input_in))
    else $error("automute not watching serial input");
  chk_man_tie: assert property (
    tie_man_q[`CMCSB_MAN_EN] |=>
    tie_sw_out.mono == $past(tie_man_q[`CMCSB_MAN_MONO]))
    else $error("manual mono tie switch not applied");

  cov_short_frame: cover property (sf_event);
  cov_flush: cover property (dsp_flush_out);
  cov_notch_use: cover property ($rose(notch_use_out));
  cov_manual_tie: cover property (tie_man_q[`CMCSB_MAN_EN] && tie_sw_out.mono);

endmodule // cmcsb_bank

// File: bench/cmcsb_host.sv
`timescale 1ns/100ps
module cmcsb_host (
  input wire logic core_clk_in,
  output logic wr_en_out,
  output logic [6:0] wr_addr_out,
  output logic [8:0] wr_data_out,
  output logic mclk_out,
  output logic frame_sync_out
);
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 7'h00;
    wr_data_out = 9'h000;
    mclk_out = 1'b0;
    frame_sync_out = 1'b0;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge core_clk_in);
    wr_en_out = 1'b1;
    wr_addr_out = a;
    wr_data_out = d;
    @(negedge core_clk_in);
    // idle bus shows inverse, so stale values never look valid
    wr_en_out = 1'b0;
    wr_addr_out = ~a;
    wr_data_out = ~d;
  endtask
  task automatic half();
    repeat (4) @(negedge core_clk_in);
  endtask
  // n master clock rises then a frame start; clock idle in between
  task automatic frame(input int n);
    repeat (n) begin
      mclk_out = 1'b1;
      half();
      mclk_out = 1'b0;
      half();
    end
    frame_sync_out = 1'b1;
    half();
    frame_sync_out = 1'b0;
    half();
  endtask
endmodule // cmcsb_host

// File: bench/cmcsb_bank_bench.sv
`timescale 1ns/100ps
module cmcsb_bank_bench;
  logic core_clk_in, srst_in, wr_en_in, mclk_in, frame_sync_in;
  logic if_mode_pin_in, speaker_supply_high_in, gen_os_256_in;
  logic pll_locked_in, pll_osc_in, softmute_in, notch_en_in;
  logic sample_tick_in, automute_applied_in, noise_gate_active_in;
  logic [6:0] wr_addr_in, rd_addr_in;
  logic [8:0] wr_data_in, rd_data_out, peak_to_peak_value_in, peak_value_in;
  logic [23:0] signal_mag_in, atten_in_data_in, serial_playback_input_in;
  logic [23:0] automute_data_out;
  logic [7:0] dac_gain_in;
  logic [1:0] buf_disabled_in;
  cmcsb_pkg::cmcsb_ref_sw_t pm_ref_sw_in, ref_sw_out;
  cmcsb_pkg::cmcsb_tie_sw_t auto_tie_sw_in, tie_sw_out;
  cmcsb_pkg::cmcsb_if_mode_t if_mode_out;
  logic dac_os_256_out, pll_clk_out, limiter_force_zero_out, notch_use_out;
  logic short_frame_out, dsp_flush_out, speaker_amp_stage_select_out;
  int error_cnt = 0;
  int num_checks = 0;
  int sf_cnt = 0;
  int fl_cnt = 0;
  int lim [4] = '{255, 253, 254, 255};
  logic [6:0] ra [4] = '{7'h49, 7'h4b, 7'h4e, 7'h4f};
  typedef struct packed {
    logic [6:0] a;
    logic [8:0] d;
    logic [4:0] s;
    logic [8:0] e;
  } cmcsb_row_t;
  // s: mag above limit, gain zero, automute, gate, supply high
  cmcsb_row_t rows [13] = '{
    '{7'h49, 9'h1ff, 5'h00, 9'h1ff},
    '{7'h4b, 9'h1ff, 5'h00, 9'h087},
    '{7'h4f, 9'h1ff, 5'h00, 9'h1f8},
    '{7'h4e, 9'h1ff, 5'h00, 9'h040},
    '{7'h4a, 9'h1ff, 5'h00, 9'h000},
    '{7'h4c, 9'h1ff, 5'h00, 9'h1a5},
    '{7'h4d, 9'h1ff, 5'h00, 9'h05a},
    '{7'h4e, 9'h000, 5'h10, 9'h001},
    '{7'h4e, 9'h000, 5'h08, 9'h004},
    '{7'h4e, 9'h000, 5'h04, 9'h008},
    '{7'h4e, 9'h000, 5'h02, 9'h010},
    '{7'h4e, 9'h000, 5'h01, 9'h020},
    '{7'h4e, 9'h000, 5'h00, 9'h000}};
  ////////////////////////////////////////
  cmcsb_bank dut (.core_clk_in, .srst_in, .wr_en_in, .wr_addr_in,
    .wr_data_in, .rd_addr_in, .rd_data_out, .mclk_in, .frame_sync_in,
    .if_mode_pin_in, .speaker_supply_high_in, .gen_os_256_in,
    .pll_locked_in, .pll_osc_in, .softmute_in, .notch_en_in,
    .sample_tick_in, .peak_to_peak_value_in, .peak_value_in,
    .signal_mag_in, .dac_gain_in, .automute_applied_in,
    .noise_gate_active_in, .atten_in_data_in, .serial_playback_input_in,
    .pm_ref_sw_in, .auto_tie_sw_in, .buf_disabled_in, .dac_os_256_out,
    .pll_clk_out, .limiter_force_zero_out, .notch_use_out,
    .short_frame_out, .dsp_flush_out, .if_mode_out, .ref_sw_out,
    .speaker_amp_stage_select_out, .automute_data_out, .tie_sw_out);
  cmcsb_host host (.core_clk_in, .wr_en_out(wr_en_in),
    .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in),
    .mclk_out(mclk_in), .frame_sync_out(frame_sync_in));
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // counted off the clock edge so each registered pulse is seen settled
  always @(negedge core_clk_in) begin
    if (short_frame_out === 1'b1)
      sf_cnt++;
    if (dsp_flush_out === 1'b1)
      fl_cnt++;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] seen,
                     input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge core_clk_in);
  endtask
  task automatic rd(input logic [6:0] a, output logic [8:0] v);
    @(negedge core_clk_in);
    rd_addr_in = a;
    repeat (2) @(negedge core_clk_in);
    v = rd_data_out;
  endtask
  task automatic tick();
    @(negedge core_clk_in);
    sample_tick_in = 1'b1;
    @(negedge core_clk_in);
    sample_tick_in = 1'b0;
  endtask
  // pulses counted over one frame, against the expected count
  task automatic frm(input int n, input int sf, input int fl);
    int s0;
    int f0;
    s0 = sf_cnt;
    f0 = fl_cnt;
    host.frame(n);
    repeat (8) @(negedge core_clk_in);
    chk("short_frame", 24'(sf_cnt - s0), 24'(sf));
    chk("dsp_flush", 24'(fl_cnt - f0), 24'(fl));
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge core_clk_in);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [8:0] v;
    srst_in = 1'b1;
    rd_addr_in = 7'h00;
    {if_mode_pin_in, speaker_supply_high_in, gen_os_256_in} = 3'b000;
    {pll_locked_in, pll_osc_in, softmute_in, notch_en_in} = 4'b0110;
    {sample_tick_in, automute_applied_in, noise_gate_active_in} = 3'b000;
    peak_to_peak_value_in = 9'h1a5;
    peak_value_in = 9'h05a;
    signal_mag_in = 24'h00_0000;
    dac_gain_in = 8'h01;
    atten_in_data_in = 24'h12_3456;
    serial_playback_input_in = 24'hab_cdef;
    pm_ref_sw_in = 3'b000;
    auto_tie_sw_in = 5'b01010;
    buf_disabled_in = 2'b10;
    repeat (16) @(negedge core_clk_in);
    srst_in = 1'b0;
    chk("if_mode_reset", if_mode_out, 24'h00_0004);
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reg_reset", v, 24'h00_0000);
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      signal_mag_in = rows[i].s[4] ? 24'he0_0001 : 24'he0_0000;
      dac_gain_in = {7'h00, ~rows[i].s[3]};
      automute_applied_in = rows[i].s[2];
      noise_gate_active_in = rows[i].s[1];
      speaker_supply_high_in = rows[i].s[0];
      settle();
      rd(rows[i].a, v);
      chk("reg_read", v, rows[i].e);
    end
    // oversampling, pll gating, softmute zero together
    host.wr(7'h49, 9'h007);
    settle();
    chk("os256", dac_os_256_out, 24'h00_0001);
    chk("pll_clk", pll_clk_out, 24'h00_0001);
    chk("force_zero", limiter_force_zero_out, 24'h00_0001);
    host.wr(7'h49, 9'h000);
    settle();
    chk("os256", dac_os_256_out, 24'h00_0000);
    chk("pll_clk", pll_clk_out, 24'h00_0000);
    chk("force_zero", limiter_force_zero_out, 24'h00_0000);
    gen_os_256_in = 1'b1;
    settle();
    chk("os256_gen", dac_os_256_out, 24'h00_0001);
    // control port mode
    if_mode_pin_in = 1'b1;
    settle();
    chk("if_mode", if_mode_out, 24'h00_0002);
    host.wr(7'h49, 9'h100);
    if_mode_pin_in = 1'b0;
    settle();
    chk("if_mode", if_mode_out, 24'h00_0001);
    host.wr(7'h49, 9'h000);
    settle();
    chk("if_mode", if_mode_out, 24'h00_0004);
    // reference ties and speaker stage
    pm_ref_sw_in = 3'b010;
    host.wr(7'h4b, 9'h081);
    settle();
    chk("ref_sw", ref_sw_out, 24'h00_0003);
    chk("stage", speaker_amp_stage_select_out, 24'h00_0001);
    pm_ref_sw_in = 3'b000;
    host.wr(7'h4b, 9'h004);
    settle();
    chk("ref_sw", ref_sw_out, 24'h00_0004);
    chk("stage", speaker_amp_stage_select_out, 24'h00_0000);
    // manual tie-off: hi buffer disabled, lo buffer running
    host.wr(7'h4f, 9'h1a8);
    settle();
    chk("tie_sw_man", tie_sw_out, 24'h00_001d);
    host.wr(7'h4f, 9'h0a8);
    settle();
    chk("tie_sw_auto", tie_sw_out, 24'h00_000a);
    // automute observation point
    host.wr(7'h4e, 9'h040);
    settle();
    chk("am_data", automute_data_out, 24'hab_cdef);
    host.wr(7'h4e, 9'h000);
    settle();
    chk("am_data", automute_data_out, 24'h12_3456);
    // notch delay: one tick short, then exact count
    notch_en_in = 1'b1;
    settle();
    repeat (511) tick();
    settle();
    chk("notch_wait", notch_use_out, 24'h00_0000);
    tick();
    settle();
    chk("notch_use", notch_use_out, 24'h00_0001);
    notch_en_in = 1'b0;
    host.wr(7'h49, 9'h008);
    settle();
    chk("notch_off", notch_use_out, 24'h00_0000);
    notch_en_in = 1'b1;
    settle();
    chk("notch_now", notch_use_out, 24'h00_0001);
    // short frames: first sync only arms the detector
    host.wr(7'h49, 9'h000);
    frm(10, 0, 0);
    for (int i = 0; i < 4; i++) begin
      host.wr(7'h49, {1'b0, 2'(i), 6'h20});
      frm(lim[i], 0, 0);
      frm(lim[i] - 1, 1, 1);
    end
    host.wr(7'h49, 9'h000);
    frm(100, 1, 0);
    host.wr(7'h49, 9'h010);
    frm(100, 0, 0);
    host.wr(7'h49, 9'h000);
    frm(100, 1, 0);
    // mid-run reset must clear registers that hold non-zero values
    host.wr(7'h4b, 9'h087);
    host.wr(7'h4f, 9'h1a8);
    @(negedge core_clk_in);
    srst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    srst_in = 1'b0;
    chk("if_mode_rerst", if_mode_out, 24'h00_0004);
    chk("stage_rerst", speaker_amp_stage_select_out, 24'h0);
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reg_rerst", v, 24'h00_0000);
    end
    settle();
    chk("tie_sw_rerst", tie_sw_out, 24'h00_000a);
    summarize();
  end
endmodule // cmcsb_bank_bench
